// File: pfc_map.svh
// Register offsets, field positions and timing constants of the pause block
`ifndef PFC_MAP_SVH
`define PFC_MAP_SVH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define PFC_PCS_OFFSET 12'h044
`define PFC_IRQ_STATUS_OFFSET 12'h050
`define PFC_IRQ_MASK_OFFSET 12'h054
`define PFC_PCS_RESET 32'h0000_0000

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PFC_BIT_MANUAL_EN 31
`define PFC_BIT_RESERVED_GRP 30
`define PFC_BIT_DEST_MATCH 29
`define PFC_BIT_ACTIVE 23
`define PFC_BIT_SEEN 22
`define PFC_BIT_NEG 21
`define PFC_BIT_LOAD 16
`define PFC_CNT_MSB 15

// ---------------------------------------------------------------
// Interrupt status bits
// ---------------------------------------------------------------
`define PFC_IRQ_FRAME 0
`define PFC_IRQ_START 1
`define PFC_IRQ_END 2
`define PFC_IRQ_W 3

// ---------------------------------------------------------------
// Frame constants and timing
// ---------------------------------------------------------------
`define PFC_PAUSE_GROUP_ADDR 48'h0180_c200_0001
`define PFC_SLOT_BITS 512
`define PFC_BIT_TIME_PS 10000
`define PFC_CLK_PERIOD_PS 10000
`define PFC_SLOT_CYCLES ((`PFC_SLOT_BITS * `PFC_BIT_TIME_PS) / `PFC_CLK_PERIOD_PS)

`endif

// File: pfc_pkg.sv
// Types shared by the pause flow control block
`default_nettype none
package pfc_pkg;
    typedef struct packed {
        logic valid;
        logic [47:0] dest;
        logic dest_match;
        logic [15:0] quanta;
    } pfc_frame_t;
endpackage : pfc_pkg
`default_nettype wire

// File: pfc_pause_ctrl.sv
// Pause frame reception, pause interval timer and control/status register
//
// The APB interface to the registers was left to the implementer.
`include "pfc_map.svh"
`default_nettype none
module pfc_pause_ctrl #(
    parameter int SLOT_CYCLES = `PFC_SLOT_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pfc_pkg::pfc_frame_t rx_frame,
    input wire logic autoneg_pause,
    input wire logic advertise_pause,
    output logic tx_hold,
    output logic irq
);
    import pfc_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic man_en_q, man_en_d;
    logic grp_en_q, grp_en_d;
    logic da_en_q, da_en_d;
    logic seen_q, seen_d;
    logic neg_q, neg_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] slot_q, slot_d;
    logic [`PFC_IRQ_W-1:0] ists_q, ists_d;
    logic [`PFC_IRQ_W-1:0] imask_q, imask_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    logic tx_hold_d, irq_d;

    logic active;
    logic rx_enable;
    logic accept;
    logic wr, rd;
    logic hit_pcs, hit_sts, hit_msk;
    logic man_load;
    logic stop;
    logic ends;
    logic [`PFC_IRQ_W-1:0] events;
    logic [31:0] pcs_view;

    assign active = (cnt_q != 16'h0000);

    // ---------------------------------------------------------------
    // Frame filter and bus decode
    // ---------------------------------------------------------------
    always_comb begin
        rx_enable = man_en_q | neg_q;
        accept = rx_enable & rx_frame.valid &
            ((grp_en_q & (rx_frame.dest == `PFC_PAUSE_GROUP_ADDR)) |
             (da_en_q & rx_frame.dest_match));
        wr = psel & penable & pwrite & pready_q_n();
        rd = psel & ~penable & ~pwrite;
        hit_pcs = (paddr == `PFC_PCS_OFFSET);
        hit_sts = (paddr == `PFC_IRQ_STATUS_OFFSET);
        hit_msk = (paddr == `PFC_IRQ_MASK_OFFSET);
        man_load = wr & hit_pcs & pwdata[`PFC_BIT_LOAD] & ~seen_q & ~active;
        stop = wr & hit_pcs & man_en_q & ~pwdata[`PFC_BIT_MANUAL_EN];
        pcs_view = 32'h0000_0000;
        pcs_view[`PFC_BIT_MANUAL_EN] = man_en_q;
        pcs_view[`PFC_BIT_RESERVED_GRP] = grp_en_q;
        pcs_view[`PFC_BIT_DEST_MATCH] = da_en_q;
        pcs_view[`PFC_BIT_ACTIVE] = active;
        pcs_view[`PFC_BIT_SEEN] = seen_q;
        pcs_view[`PFC_BIT_NEG] = neg_q;
        pcs_view[`PFC_CNT_MSB:0] = cnt_q;
    end

    function automatic logic pready_q_n();
        pready_q_n = 1'b1;
    endfunction : pready_q_n

    // ---------------------------------------------------------------
    // Pause timer and control bits
    // ---------------------------------------------------------------
    always_comb begin
        man_en_d = man_en_q;
        grp_en_d = grp_en_q;
        da_en_d = da_en_q;
        cnt_d = cnt_q;
        slot_d = slot_q;
        seen_d = seen_q;
        ends = 1'b0;
        neg_d = autoneg_pause & advertise_pause;
        if (wr && hit_pcs) begin
            man_en_d = pwdata[`PFC_BIT_MANUAL_EN];
            grp_en_d = pwdata[`PFC_BIT_RESERVED_GRP];
            da_en_d = pwdata[`PFC_BIT_DEST_MATCH];
        end
        if (active) begin
            if (slot_q == 16'(SLOT_CYCLES - 1)) begin
                slot_d = 16'h0000;
                cnt_d = cnt_q - 16'h0001;
                ends = (cnt_q == 16'h0001);
            end else begin
                slot_d = slot_q + 16'h0001;
            end
        end else begin
            slot_d = 16'h0000;
        end
        if (accept) begin
            cnt_d = rx_frame.quanta;
            slot_d = 16'h0000;
            seen_d = 1'b1;
            ends = 1'b0;
        end else if (man_load) begin
            cnt_d = pwdata[`PFC_CNT_MSB:0];
            slot_d = 16'h0000;
        end
        if (stop) begin
            cnt_d = 16'h0000;
            slot_d = 16'h0000;
            ends = active;
        end
        if ((cnt_d == 16'h0000) && !accept) begin
            seen_d = 1'b0;
        end
        tx_hold_d = (cnt_d != 16'h0000);
    end

    // ---------------------------------------------------------------
    // Interrupts and APB answer
    // ---------------------------------------------------------------
    always_comb begin
        events = '0;
        events[`PFC_IRQ_FRAME] = accept;
        events[`PFC_IRQ_START] = (cnt_q == 16'h0000) && (cnt_d != 16'h0000);
        events[`PFC_IRQ_END] = ends;
        ists_d = ists_q;
        imask_d = imask_q;
        if (wr && hit_sts) begin
            ists_d = ists_q & ~pwdata[`PFC_IRQ_W-1:0];
        end
        if (wr && hit_msk) begin
            imask_d = pwdata[`PFC_IRQ_W-1:0];
        end
        ists_d = ists_d | events;
        irq_d = |(ists_d & imask_d);
        prdata_d = 32'h0000_0000;
        pslverr_d = 1'b0;
        if (psel && !penable) begin
            if (!(hit_pcs || hit_sts || hit_msk)) begin
                pslverr_d = 1'b1;
            end else if (rd && hit_pcs) begin
                prdata_d = pcs_view;
            end else if (rd && hit_sts) begin
                prdata_d[`PFC_IRQ_W-1:0] = ists_q;
            end else if (rd && hit_msk) begin
                prdata_d[`PFC_IRQ_W-1:0] = imask_q;
            end
        end else if (psel && penable) begin
            prdata_d = prdata;
            pslverr_d = pslverr;
        end
        pready_d = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            man_en_q <= 1'b0;
            grp_en_q <= 1'b0;
            da_en_q <= 1'b0;
            seen_q <= 1'b0;
            neg_q <= 1'b0;
            cnt_q <= 16'h0000;
            slot_q <= 16'h0000;
            ists_q <= '0;
            imask_q <= '0;
            prdata <= `PFC_PCS_RESET;
            pready <= 1'b0;
            pslverr <= 1'b0;
            tx_hold <= 1'b0;
            irq <= 1'b0;
        end else begin
            man_en_q <= man_en_d;
            grp_en_q <= grp_en_d;
            da_en_q <= da_en_d;
            seen_q <= seen_d;
            neg_q <= neg_d;
            cnt_q <= cnt_d;
            slot_q <= slot_d;
            ists_q <= ists_d;
            imask_q <= imask_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
            tx_hold <= tx_hold_d;
            irq <= irq_d;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    AST_MANUAL_STOP: assert property (@(posedge pclk) disable iff (!presetn)
        (stop && !accept) |=> (cnt_q == 16'h0000))
        else $error("Manual enable clear did not end interval");
    AST_GROUP_ACCEPT: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_frame.valid && man_en_q && grp_en_q && rx_frame.dest == `PFC_PAUSE_GROUP_ADDR && !stop)
        |=> (cnt_q == $past(rx_frame.quanta)))
        else $error("Group address pause frame not loaded");
    AST_DISABLED_IGNORE: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_frame.valid && !man_en_q && !neg_q && !man_load && cnt_q == 16'h0000)
        |=> (cnt_q == 16'h0000))
        else $error("Frame accepted while reception disabled");
    AST_ACTIVE_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (rd && hit_pcs) |=> (prdata[`PFC_BIT_ACTIVE] == $past(cnt_q != 16'h0000)))
        else $error("Active flag read wrong");
    AST_SEEN_HELD: assert property (@(posedge pclk) disable iff (!presetn)
        (seen_q && cnt_q > 16'h0001 && !stop) |=> seen_q)
        else $error("Seen flag dropped early");
    AST_NEG: assert property (@(posedge pclk) disable iff (!presetn)
        neg_q |-> $past(advertise_pause))
        else $error("Negotiated bit set without advertising");
    AST_LOAD_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_pcs && pwdata[`PFC_BIT_LOAD] && !accept && !stop && cnt_q > 16'h0001)
        |=> (cnt_q == $past(cnt_q) || cnt_q == $past(cnt_q) - 16'h0001))
        else $error("Manual load taken during interval");
    AST_LOAD_READ0: assert property (@(posedge pclk) disable iff (!presetn)
        (rd && hit_pcs) |=> (prdata[`PFC_BIT_LOAD] == 1'b0 && prdata[28:24] == 5'h00 && prdata[20:17] == 4'h0))
        else $error("Load or unused bits read nonzero");
    AST_SLOT_DEC: assert property (@(posedge pclk) disable iff (!presetn)
        (active && slot_q == 16'(SLOT_CYCLES - 1) && !accept && !man_load && !stop)
        |=> (cnt_q == $past(cnt_q) - 16'h0001))
        else $error("Counter did not decrement at slot end");
    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (cnt_q != 16'h0000) |-> tx_hold)
        else $error("Transmit not held during interval");

    // ---------------------------------------------------------------
    // Filter, load, flag, timer, interrupt and bus checks
    // ---------------------------------------------------------------
    AST_RX_BY_NEG: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_frame.valid && neg_q && !man_en_q && grp_en_q && rx_frame.dest == `PFC_PAUSE_GROUP_ADDR)
        |=> (cnt_q == $past(rx_frame.quanta)))
        else $error("Negotiated reception ignored a frame");
    AST_STOP_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
        (stop && active && !accept) |=> ists_q[`PFC_IRQ_END])
        else $error("Manual stop did not flag interval end");
    AST_GROUP_EXACT: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_frame.valid && grp_en_q && !da_en_q && rx_frame.dest != `PFC_PAUSE_GROUP_ADDR
            && !man_load && !active)
        |=> (cnt_q == 16'h0000))
        else $error("Frame to other address accepted");
    AST_DEST_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_frame.valid && man_en_q && da_en_q && rx_frame.dest_match && !stop)
        |=> (cnt_q == $past(rx_frame.quanta)))
        else $error("Destination match frame not loaded");
    AST_SEEN_SET: assert property (@(posedge pclk) disable iff (!presetn)
        accept |=> seen_q)
        else $error("Seen flag not set by accepted frame");
    AST_SEEN_END: assert property (@(posedge pclk) disable iff (!presetn)
        (active && cnt_d == 16'h0000 && !accept) |=> (!seen_q && !tx_hold))
        else $error("Seen flag or hold left after interval end");
    AST_NEG_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (autoneg_pause && advertise_pause) |=> neg_q)
        else $error("Negotiated bit not set");
    AST_MANUAL_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_pcs && pwdata[`PFC_BIT_LOAD] && !seen_q && !active && !accept && !stop)
        |=> (cnt_q == $past(pwdata[`PFC_CNT_MSB:0])))
        else $error("Manual load not taken while idle");
    AST_COUNT_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (rd && hit_pcs) |=> (prdata[`PFC_CNT_MSB:0] == $past(cnt_q)))
        else $error("Count field read not live");
    AST_SLOT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (active && slot_q != 16'(SLOT_CYCLES - 1) && !accept && !man_load && !stop)
        |=> (cnt_q == $past(cnt_q)))
        else $error("Counter moved inside a slot");
    AST_ERR_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !(hit_pcs || hit_sts || hit_msk)) |=> pslverr)
        else $error("Unmapped access gave no error");
    AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(ists_q & imask_q))
        else $error("Interrupt level wrong");
    AST_EVENT_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        (events != '0) |=> ((ists_q & $past(events)) == $past(events)))
        else $error("Interrupt event lost");
endmodule : pfc_pause_ctrl
`default_nettype wire

// File: pfc_remote_station.sv
// Remote station model that sends pause frames
`default_nettype none
module pfc_remote_station (
    input wire logic pclk,
    output var pfc_pkg::pfc_frame_t rx_frame
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_frame = '0;
    end
    // One-cycle frame pulse, then garbage on the idle fields
    task automatic send(input logic [47:0] d, input logic m, input logic [15:0] q);
        @(posedge pclk);
        rx_frame <= '{valid: 1'b1, dest: d, dest_match: m, quanta: q};
        @(posedge pclk);
        rx_frame <= '{valid: 1'b0, dest: ~d, dest_match: ~m, quanta: ~q};
    endtask : send
endmodule : pfc_remote_station
`default_nettype wire

// File: test_pause_frame_flow_control.sv
// Testbench of the pause flow control block
`include "pfc_map.svh"
`default_nettype none
module test_pause_frame_flow_control;
    timeunit 1ns;
    timeprecision 1ps;
    import pfc_pkg::*;
    localparam int SLOT = 4;
    localparam logic [11:0] PCS = `PFC_PCS_OFFSET;
    localparam logic [47:0] GRP = `PFC_PAUSE_GROUP_ADDR;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic autoneg_pause, advertise_pause, tx_hold, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    pfc_frame_t rx_frame;
    int errors, num_checks, len, q, k;
    logic en, mc, da, neg, dm, acc;
    logic [47:0] dst;
    pfc_pause_ctrl #(.SLOT_CYCLES(SLOT)) i_pfc_pause_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_frame(rx_frame), .autoneg_pause(autoneg_pause),
        .advertise_pause(advertise_pause), .tx_hold(tx_hold), .irq(irq));
    pfc_remote_station i_pfc_remote_station (.pclk(pclk), .rx_frame(rx_frame));
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            if (++n > 50) begin errors++; end_sim(); end
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rdc
    task automatic hold_len;
        int n;
        n = 0; len = 0;
        while (tx_hold !== 1'b1) begin
            if (++n > 20) begin errors++; end_sim(); end
            @(negedge pclk);
        end
        while (tx_hold === 1'b1) begin
            if (++len > 5000) begin errors++; end_sim(); end
            @(negedge pclk);
        end
    endtask : hold_len
    // ---------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ---------------------------------------------------------------
    initial begin pclk = 1'b0; forever #5 pclk = ~pclk; end
    initial begin repeat (100000) @(posedge pclk); errors++; end_sim(); end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        autoneg_pause = 1'b0; advertise_pause = 1'b0; errors = 0; num_checks = 0;
        k = $urandom(93);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdc("pcs reset", PCS, `PFC_PCS_RESET);
        apb(1'b1, PCS, 32'he1fe_0005);
        rdc("pcs ro bits", PCS, 32'he000_0000);
        for (int i = 0; i < 4; i++) begin
            autoneg_pause <= i[0]; advertise_pause <= i[1];
            rdc("neg bit", PCS, 32'he000_0000 | (32'(i == 3) << 21));
        end
        apb(1'b1, `PFC_IRQ_MASK_OFFSET, 32'h0);
        for (int i = 0; i < 14; i++) begin
            {en, mc, da, neg} = (i == 0) ? 4'hc : 4'($urandom);
            autoneg_pause <= neg; advertise_pause <= neg;
            k = $urandom % 3;
            dst = (k == 0 || i == 0) ? GRP : (k == 1) ? GRP ^ 48'h1 : {$urandom, 16'($urandom)};
            dm = 1'($urandom); q = 1 + $urandom % 6;
            acc = (en | neg) & ((mc & dst == GRP) | (da & dm));
            apb(1'b1, PCS, {en, mc, da, 29'h0});
            i_pfc_remote_station.send(dst, dm, 16'(q));
            if (acc) begin
                apb(1'b0, PCS, 32'h0);
                chk("pcs flags", {en, mc, da, 7'h03, neg, 21'h0}, rd & 32'hffff_0000);
                chk("pcs count", 1, 32'(rd[15:0] <= q && rd[15:0] + 1 >= q));
                hold_len();
                chk("hold len", 1, 32'(len >= (q - 1) * SLOT && len <= q * SLOT + 2));
                rdc("pcs after", PCS, {en, mc, da, 7'h0, neg, 21'h0});
            end else begin
                repeat (3) @(negedge pclk);
                chk("ignored", 0, 32'(tx_hold));
            end
        end
        rdc("irq status", `PFC_IRQ_STATUS_OFFSET, 32'h7);
        chk("irq masked", 0, 32'(irq));
        apb(1'b1, `PFC_IRQ_MASK_OFFSET, 32'h2);
        repeat (2) @(negedge pclk);
        chk("irq on", 1, 32'(irq));
        apb(1'b1, `PFC_IRQ_STATUS_OFFSET, 32'h2);
        repeat (2) @(negedge pclk);
        chk("irq off", 0, 32'(irq));
        rdc("irq w1c", `PFC_IRQ_STATUS_OFFSET, 32'h5);
        autoneg_pause <= 1'b0;
        apb(1'b1, PCS, 32'h8001_0006);
        rdc("manual flags", PCS, 32'h8080_0006);
        chk("manual count", 1, 32'(rd[15:0] <= 6 && rd[15:0] >= 5));
        apb(1'b1, PCS, 32'h8001_0030);
        apb(1'b0, PCS, 32'h0);
        chk("load refused", 1, 32'(rd[15:0] <= 6 && rd[15:0] >= 4));
        apb(1'b1, PCS, 32'h0);
        repeat (3) @(negedge pclk);
        chk("end by clear", 0, 32'(tx_hold));
        rdc("pcs cleared", PCS, 32'h0);
        apb(1'b0, 12'h060, 32'h0);
        chk("unmapped err", 1, 32'(err));
        chk("unmapped data", 0, rd);
        apb(1'b1, 12'h060, 32'hffff_ffff);
        chk("unmapped wr err", 1, 32'(err));
        rdc("pcs untouched", PCS, 32'h0);
        end_sim();
    end
endmodule : test_pause_frame_flow_control
`default_nettype wire
